// ===== hw/oie_cycle.v
// Cycle timing watcher producing new-cycle, sixty-four-second and missed-cycle pulses.
`timescale 1ns/100ps
module oie_cycle (
	input wire aclk,
	input wire aresetn,
	input wire cycle_count_lsb,
	input wire seconds_bit,
	input wire cycle_start,
	input wire subaction_gap,
	input wire arb_reset_gap,
	output reg new_cycle_pulse,
	output reg sixty_four_pulse,
	output reg missed_cycle_pulse
);
	reg count_lsb_prev_reg;
	reg seconds_prev_reg;
	reg start_prev_reg;
	reg gap_prev_reg;
	reg arb_prev_reg;
	reg armed_reg;
	reg start_seen_reg;
	reg gap_seen_reg;
	reg predicted_reg;
	wire cycle_tick;
	wire start_rise;
	wire gap_rise;
	wire arb_rise;
	wire predict_now;
	wire lost_at_tick;

	assign cycle_tick = cycle_count_lsb ^ count_lsb_prev_reg;
	assign start_rise = cycle_start & ~start_prev_reg;
	assign gap_rise = subaction_gap & ~gap_prev_reg;
	assign arb_rise = arb_reset_gap & ~arb_prev_reg;
	// A second gap or an arbitration reset gap before any cycle start forecasts the loss.
	assign predict_now = armed_reg & ~start_seen_reg & ~start_rise & ~predicted_reg &
		((gap_rise & gap_seen_reg) | arb_rise);
	// The first tick after reset has no previous cycle to judge.
	assign lost_at_tick = cycle_tick & armed_reg & ~start_seen_reg & ~predicted_reg;

	//////////////////////////////////////////////////////////////////////////////////////
	always @(posedge aclk) begin
		if (!aresetn) begin
			count_lsb_prev_reg <= 1'b0;
			seconds_prev_reg <= 1'b0;
			start_prev_reg <= 1'b0;
			gap_prev_reg <= 1'b0;
			arb_prev_reg <= 1'b0;
			armed_reg <= 1'b0;
			start_seen_reg <= 1'b0;
			gap_seen_reg <= 1'b0;
			predicted_reg <= 1'b0;
			new_cycle_pulse <= 1'b0;
			sixty_four_pulse <= 1'b0;
			missed_cycle_pulse <= 1'b0;
		end else begin
			count_lsb_prev_reg <= cycle_count_lsb;
			seconds_prev_reg <= seconds_bit;
			start_prev_reg <= cycle_start;
			gap_prev_reg <= subaction_gap;
			arb_prev_reg <= arb_reset_gap;
			new_cycle_pulse <= cycle_tick;
			sixty_four_pulse <= seconds_bit ^ seconds_prev_reg;
			missed_cycle_pulse <= lost_at_tick | predict_now;
			if (cycle_tick) begin
				armed_reg <= 1'b1;
				start_seen_reg <= start_rise;
				gap_seen_reg <= 1'b0;
				predicted_reg <= 1'b0;
			end else begin
				if (start_rise) begin
					start_seen_reg <= 1'b1;
				end
				if (gap_rise) begin
					gap_seen_reg <= 1'b1;
				end
				if (predict_now) begin
					predicted_reg <= 1'b1;
				end
			end
		end
	end
endmodule

// ===== hw/oie_regs.vh
// Register offsets, field positions and constant values of the interrupt event block.
`ifndef OIE_REGS_VH
`define OIE_REGS_VH

`define OIE_ADDR_W 8
`define OIE_EVENT_SET_ADDR 8'h80
`define OIE_EVENT_CLR_ADDR 8'h84

`define OIE_EVENT_W 23
`define OIE_EVENT_RESET 23'h000000
`define OIE_WRITABLE_MASK 23'h7f833f

`define OIE_BIT_MISSED_CYCLE 22
`define OIE_BIT_SIXTY_FOUR_SEC 21
`define OIE_BIT_NEW_ISO_CYCLE 20
`define OIE_BIT_PHY_STATUS 19
`define OIE_BIT_REG_ACCESS_FAIL 18
`define OIE_BIT_BUS_RESET 17
`define OIE_BIT_SELF_ID_DONE 16
`define OIE_BIT_SELF_ID_STICKY 15
`define OIE_BIT_LOCK_RESP_ERR 9
`define OIE_BIT_POSTED_WR_ERR 8
`define OIE_BIT_ISO_RX_SUMMARY 7
`define OIE_BIT_ISO_TX_SUMMARY 6
`define OIE_BIT_RSP_PKT 5
`define OIE_BIT_REQ_PKT 4
`define OIE_BIT_RX_RSP_DMA 3
`define OIE_BIT_RX_REQ_DMA 2
`define OIE_BIT_RSP_TX_DONE 1
`define OIE_BIT_REQ_TX_DONE 0

`define OIE_IRQ_ALWAYS 2'b11
`define OIE_RESP_OKAY 2'b00
`define OIE_RESP_SLVERR 2'b10

`endif

// ===== hw/oie_sync.v
// Two flip-flop synchroniser for a vector of independent pin levels.
`timescale 1ns/100ps
module oie_sync #(
	parameter W = 9
) (
	input wire aclk,
	input wire aresetn,
	input wire [W-1:0] async_in,
	output reg [W-1:0] sync_out
);
	reg [W-1:0] stage1_reg;

	// The first stage feeds only the second stage, so a metastable level never fans out.
	always @(posedge aclk) begin
		if (!aresetn) begin
			stage1_reg <= {W{1'b0}};
			sync_out <= {W{1'b0}};
		end else begin
			stage1_reg <= async_in;
			sync_out <= stage1_reg;
		end
	end
endmodule

// ===== hw/oie_top.v
// Interrupt event register, low bits, with AXI4-Lite set and clear aliases.
//
// Functional notes
// - Flag missed cycle when no cycle start occurs between two new-cycle ticks.
// - Missed cycle may be flagged early by gap or arbitration reset prediction.
// - Flag sixty-four-second event when the watched seconds bit changes.
// - Flag new isochronous cycle when cycle count low bit toggles.
// - Flag PHY status event when the PHY requests an interrupt.
// - Flag register access failure when an access finds the link clock absent.
// - Flag bus reset event when the PHY enters bus reset.
// - Self-ID done sets on stream end, clears as bus reset sets.
// - Sticky self-ID copy sets with self-ID done, ignores bus reset.
// - Bits ten to fourteen always read zero.
// - Flag lock response error when lock response gets no ack_complete.
// - Flag posted write error on host bus error writing acknowledged data.
// - Receive summary is OR of masked receive context events, not latched.
// - Transmit summary is OR of masked transmit context events, not latched.
// - Flag response packet received after buffer and descriptor update.
// - Flag request packet received after buffer and descriptor update.
// - Receive response DMA bit sets on descriptor completion, conditionally.
// - Receive request DMA bit sets on descriptor completion, conditionally.
// - Response transmit done sets on command completion, conditionally.
// - Request transmit done sets on command completion, conditionally.
// - Bits set by source rising edge or set alias; cleared by clear alias, self-ID done also by bus reset.
// - Reads return event bits ANDed with interrupt mask bits.
`timescale 1ns/100ps
`include "oie_regs.vh"
module oie_top #(
	parameter NUM_RX_CTX = 4,
	parameter NUM_TX_CTX = 4
) (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [22:0] interrupt_mask,
	input wire phy_status_request_pin,
	input wire phy_bus_reset_pin,
	input wire self_id_stream_done_pin,
	input wire link_clock_alive_pin,
	input wire cycle_count_lsb_pin,
	input wire cycle_seconds_bit_pin,
	input wire cycle_start_pin,
	input wire subaction_gap_pin,
	input wire arb_reset_gap_pin,
	input wire core_reg_access,
	input wire lock_response_no_ack,
	input wire posted_write_host_error,
	input wire response_packet_stored,
	input wire request_packet_stored,
	input wire async_receive_response_dma_done,
	input wire [1:0] async_receive_response_dma_irq,
	input wire async_receive_request_dma_done,
	input wire [1:0] async_receive_request_dma_irq,
	input wire async_transmit_response_context_done,
	input wire [1:0] async_transmit_response_context_irq,
	input wire async_transmit_request_context_done,
	input wire [1:0] async_transmit_request_context_irq,
	input wire [NUM_RX_CTX-1:0] iso_rx_ctx_event,
	input wire [NUM_RX_CTX-1:0] iso_rx_ctx_mask,
	input wire [NUM_TX_CTX-1:0] iso_tx_ctx_event,
	input wire [NUM_TX_CTX-1:0] iso_tx_ctx_mask,
	output reg [22:0] event_status
);
	//////////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisation and cycle timing.

	wire [8:0] pins_async;
	wire [8:0] pins_sync;
	wire new_cycle_pulse;
	wire sixty_four_pulse;
	wire missed_cycle_pulse;
	wire phy_status_sync;
	wire bus_reset_sync;
	wire self_id_done_sync;
	wire link_alive_sync;
	wire cycle_lsb_sync;
	wire seconds_sync;
	wire cycle_start_sync;
	wire subaction_gap_sync;
	wire arb_gap_sync;

	assign pins_async = {arb_reset_gap_pin, subaction_gap_pin, cycle_start_pin,
		cycle_seconds_bit_pin, cycle_count_lsb_pin, link_clock_alive_pin,
		self_id_stream_done_pin, phy_bus_reset_pin, phy_status_request_pin};

	oie_sync #(
		.W(9)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in(pins_async),
		.sync_out(pins_sync)
	);

	assign phy_status_sync = pins_sync[0];
	assign bus_reset_sync = pins_sync[1];
	assign self_id_done_sync = pins_sync[2];
	assign link_alive_sync = pins_sync[3];
	assign cycle_lsb_sync = pins_sync[4];
	assign seconds_sync = pins_sync[5];
	assign cycle_start_sync = pins_sync[6];
	assign subaction_gap_sync = pins_sync[7];
	assign arb_gap_sync = pins_sync[8];

	oie_cycle u_cycle (
		.aclk(aclk),
		.aresetn(aresetn),
		.cycle_count_lsb(cycle_lsb_sync),
		.seconds_bit(seconds_sync),
		.cycle_start(cycle_start_sync),
		.subaction_gap(subaction_gap_sync),
		.arb_reset_gap(arb_gap_sync),
		.new_cycle_pulse(new_cycle_pulse),
		.sixty_four_pulse(sixty_four_pulse),
		.missed_cycle_pulse(missed_cycle_pulse)
	);

	//////////////////////////////////////////////////////////////////////////////////////
	// Event sources, taken on their rising edge.

	reg [22:0] source_prev_reg;
	reg [22:0] source_level;
	wire [22:0] hw_set;
	wire reg_fail_set;
	wire rx_rsp_dma_set;
	wire rx_req_dma_set;
	wire rsp_tx_done_set;
	wire req_tx_done_set;

	// An access while the link clock is missing would hang, so it is flagged instead.
	assign reg_fail_set = core_reg_access & ~link_alive_sync;
	// A completion whose descriptor asks for no interrupt stays silent.
	assign rx_rsp_dma_set = async_receive_response_dma_done &
		(async_receive_response_dma_irq == `OIE_IRQ_ALWAYS);
	assign rx_req_dma_set = async_receive_request_dma_done &
		(async_receive_request_dma_irq == `OIE_IRQ_ALWAYS);
	assign rsp_tx_done_set = async_transmit_response_context_done &
		(async_transmit_response_context_irq == `OIE_IRQ_ALWAYS);
	assign req_tx_done_set = async_transmit_request_context_done &
		(async_transmit_request_context_irq == `OIE_IRQ_ALWAYS);

	always @* begin
		source_level = 23'h000000;
		source_level[`OIE_BIT_MISSED_CYCLE] = missed_cycle_pulse;
		source_level[`OIE_BIT_SIXTY_FOUR_SEC] = sixty_four_pulse;
		source_level[`OIE_BIT_NEW_ISO_CYCLE] = new_cycle_pulse;
		source_level[`OIE_BIT_PHY_STATUS] = phy_status_sync;
		source_level[`OIE_BIT_REG_ACCESS_FAIL] = reg_fail_set;
		source_level[`OIE_BIT_BUS_RESET] = bus_reset_sync;
		source_level[`OIE_BIT_SELF_ID_DONE] = self_id_done_sync;
		source_level[`OIE_BIT_SELF_ID_STICKY] = self_id_done_sync;
		source_level[`OIE_BIT_LOCK_RESP_ERR] = lock_response_no_ack;
		source_level[`OIE_BIT_POSTED_WR_ERR] = posted_write_host_error;
		source_level[`OIE_BIT_RSP_PKT] = response_packet_stored;
		source_level[`OIE_BIT_REQ_PKT] = request_packet_stored;
		source_level[`OIE_BIT_RX_RSP_DMA] = rx_rsp_dma_set;
		source_level[`OIE_BIT_RX_REQ_DMA] = rx_req_dma_set;
		source_level[`OIE_BIT_RSP_TX_DONE] = rsp_tx_done_set;
		source_level[`OIE_BIT_REQ_TX_DONE] = req_tx_done_set;
	end

	// A source held high sets its bit once; the edge must recur to set it again.
	assign hw_set = source_level & ~source_prev_reg & `OIE_WRITABLE_MASK;

	//////////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write channel.

	reg aw_held_reg;
	reg [7:0] aw_addr_reg;
	reg w_held_reg;
	reg [31:0] w_data_reg;
	reg [3:0] w_strb_reg;
	wire write_fire;
	wire [31:0] strobed_data;
	wire wr_is_set;
	wire wr_is_clr;
	wire wr_hit;
	wire [22:0] sw_set;
	wire [22:0] sw_clr;

	// Address and data may arrive in either order; the write fires once both are held.
	assign write_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;
	assign strobed_data = w_data_reg & {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
		{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
	assign wr_is_set = (aw_addr_reg == `OIE_EVENT_SET_ADDR);
	assign wr_is_clr = (aw_addr_reg == `OIE_EVENT_CLR_ADDR);
	assign wr_hit = wr_is_set | wr_is_clr;
	assign sw_set = (write_fire & wr_is_set) ?
		(strobed_data[22:0] & `OIE_WRITABLE_MASK) : 23'h000000;
	assign sw_clr = (write_fire & wr_is_clr) ?
		(strobed_data[22:0] & `OIE_WRITABLE_MASK) : 23'h000000;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_held_reg <= 1'b0;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `OIE_RESP_OKAY;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (write_fire) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (wr_hit) begin
					s_axi_bresp <= `OIE_RESP_OKAY;
				end else begin
					s_axi_bresp <= `OIE_RESP_SLVERR;
				end
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////
	// Event bits and unlatched isochronous summaries.

	reg [22:0] event_reg;
	reg [22:0] event_next;
	reg iso_rx_summary_reg;
	reg iso_tx_summary_reg;
	wire [22:0] visible_events;
	wire [22:0] masked_events;
	wire self_id_clear;

	// Bus reset wins over a self-ID edge that falls in the same cycle.
	assign self_id_clear = hw_set[`OIE_BIT_BUS_RESET];

	always @* begin
		// The hardware set is applied last so it survives a simultaneous clear.
		event_next = ((event_reg | sw_set) & ~sw_clr) | hw_set;
		if (self_id_clear) begin
			event_next[`OIE_BIT_SELF_ID_DONE] = 1'b0;
		end
		event_next = event_next & `OIE_WRITABLE_MASK;
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			source_prev_reg <= 23'h000000;
			event_reg <= `OIE_EVENT_RESET;
		end else begin
			source_prev_reg <= source_level;
			event_reg <= event_next;
		end
	end

	// The summaries follow their contexts and are never latched, so a clear cannot touch them.
	always @(posedge aclk) begin
		if (!aresetn) begin
			iso_rx_summary_reg <= 1'b0;
			iso_tx_summary_reg <= 1'b0;
		end else begin
			iso_rx_summary_reg <= |(iso_rx_ctx_event & iso_rx_ctx_mask);
			iso_tx_summary_reg <= |(iso_tx_ctx_event & iso_tx_ctx_mask);
		end
	end

	assign visible_events = {event_reg[22:8], iso_rx_summary_reg, iso_tx_summary_reg,
		event_reg[5:0]};
	assign masked_events = visible_events & interrupt_mask;

	always @(posedge aclk) begin
		if (!aresetn) begin
			event_status <= 23'h000000;
		end else begin
			event_status <= visible_events;
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read channel.

	wire [7:0] rd_addr;

	assign rd_addr = {s_axi_araddr[7:2], 2'b00};

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `OIE_RESP_OKAY;
		end else begin
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				// Both aliases read the same masked value; only a write tells them apart.
				if (rd_addr == `OIE_EVENT_SET_ADDR) begin
					s_axi_rdata <= {9'h000, masked_events};
					s_axi_rresp <= `OIE_RESP_OKAY;
				end else if (rd_addr == `OIE_EVENT_CLR_ADDR) begin
					s_axi_rdata <= {9'h000, masked_events};
					s_axi_rresp <= `OIE_RESP_OKAY;
				end else begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `OIE_RESP_SLVERR;
				end
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule

// ===== verification/oie_phy_model.sv
// PHY side model driving the status, bus reset, self-ID, link clock and cycle pins.
`timescale 1ns/100ps
module oie_phy_model (
	input wire aclk,
	output logic [8:0] pins
);
	// Order: status, bus reset, self-ID, link alive, cycle lsb, seconds, start, gap, arb gap.
	initial pins = 9'h008;
	////////////////////////////////////////////////////////////////////////////////
	// Pulses stay up four cycles so the synchronisers cannot miss them.
	task automatic pulse(input int i);
		@(posedge aclk);
		pins[i] <= 1'b1;
		repeat (4) @(posedge aclk);
		pins[i] <= 1'b0;
		repeat (4) @(posedge aclk);
	endtask
	task automatic toggle(input int i);
		@(posedge aclk);
		pins[i] <= ~pins[i];
		repeat (6) @(posedge aclk);
	endtask
endmodule

// ===== verification/oie_top_properties.sv
// Concurrent checks on the ports of the interrupt event block.
`timescale 1ns/100ps
`include "oie_regs.vh"
module oie_checker #(
	parameter NUM_RX_CTX = 4,
	parameter NUM_TX_CTX = 4
) (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [22:0] interrupt_mask,
	input wire lock_response_no_ack,
	input wire posted_write_host_error,
	input wire async_receive_response_dma_done,
	input wire [1:0] async_receive_response_dma_irq,
	input wire [NUM_RX_CTX-1:0] iso_rx_ctx_event,
	input wire [NUM_RX_CTX-1:0] iso_rx_ctx_mask,
	input wire [NUM_TX_CTX-1:0] iso_tx_ctx_event,
	input wire [NUM_TX_CTX-1:0] iso_tx_ctx_mask,
	input wire [22:0] event_status
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////////////////////
	a_lock_err_set: assert property ($rose(lock_response_no_ack) |-> ##[1:2] event_status[9])
		else $error("lock response error not latched");
	a_posted_err_set: assert property ($rose(posted_write_host_error)
		|-> ##[1:2] event_status[8])
		else $error("posted write error not latched");
	a_dma_irq_set: assert property ($rose(async_receive_response_dma_done)
		&& async_receive_response_dma_irq == 2'b11 |-> ##[1:2] event_status[3])
		else $error("receive response completion not latched");
	a_reserved_reads_zero: assert property (s_axi_rvalid |-> s_axi_rdata[14:10] == 5'h00)
		else $error("reserved bits read non-zero");
	a_iso_rx_rise: assert property ($rose(|(iso_rx_ctx_event & iso_rx_ctx_mask))
		|-> ##[1:2] event_status[7])
		else $error("receive summary did not follow its contexts");
	a_iso_tx_fall: assert property ($fell(|(iso_tx_ctx_event & iso_tx_ctx_mask))
		|-> ##[1:2] !event_status[6])
		else $error("transmit summary held after contexts dropped");
	a_read_masked: assert property (s_axi_arvalid && s_axi_arready
		&& s_axi_araddr[7:3] == 5'h10
		|=> (s_axi_rdata[22:0] & 23'h7f833f) == (event_status & $past(interrupt_mask) & 23'h7f833f))
		else $error("read data is not events and mask");
	a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:3] != 5'h10
		|=> s_axi_rvalid && s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_read_stands: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
	a_selfid_off: assert property ($rose(event_status[17]) |-> !event_status[16])
		else $error("self-ID done kept across bus reset");
	a_sticky_keeps: assert property ($rose(event_status[17]) && $past(event_status[15])
		|-> event_status[15])
		else $error("sticky self-ID bit lost on bus reset");
	c_missed_cycle: cover property ($rose(event_status[22]));
	c_write_refused: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
	c_read_done: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind oie_top oie_checker #(.NUM_RX_CTX(NUM_RX_CTX), .NUM_TX_CTX(NUM_TX_CTX))
	chk_u (.aclk, .aresetn,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready, .interrupt_mask, .lock_response_no_ack, .posted_write_host_error,
	.async_receive_response_dma_done, .async_receive_response_dma_irq, .iso_rx_ctx_event,
	.iso_rx_ctx_mask, .iso_tx_ctx_event, .iso_tx_ctx_mask, .event_status);

// ===== verification/tb_top.sv
// Self-checking bench for the interrupt event block.
`timescale 1ns/100ps
module tb_top;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, core_reg_access = 0, lock_response_no_ack = 0;
	logic posted_write_host_error = 0, response_packet_stored = 0, request_packet_stored = 0;
	logic async_receive_response_dma_done = 0, async_receive_request_dma_done = 0;
	logic async_transmit_response_context_done = 0, async_transmit_request_context_done = 0;
	logic [1:0] async_receive_response_dma_irq = 0, async_receive_request_dma_irq = 0;
	logic [1:0] async_transmit_response_context_irq = 0, async_transmit_request_context_irq = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [22:0] interrupt_mask = 23'h7fffff, event_status;
	logic [3:0] iso_rx_ctx_event = 0, iso_rx_ctx_mask = 0, iso_tx_ctx_event = 0, iso_tx_ctx_mask = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [8:0] pins;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [31:0] d;
	int miscompares = 0, cmp_count = 0;
	always #50 aclk = ~aclk;
	oie_phy_model phy_u (.aclk, .pins);
	oie_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .interrupt_mask,
		.phy_status_request_pin(pins[0]), .phy_bus_reset_pin(pins[1]),
		.self_id_stream_done_pin(pins[2]), .link_clock_alive_pin(pins[3]),
		.cycle_count_lsb_pin(pins[4]), .cycle_seconds_bit_pin(pins[5]), .cycle_start_pin(pins[6]),
		.subaction_gap_pin(pins[7]), .arb_reset_gap_pin(pins[8]), .core_reg_access,
		.lock_response_no_ack, .posted_write_host_error, .response_packet_stored,
		.request_packet_stored, .async_receive_response_dma_done, .async_receive_response_dma_irq,
		.async_receive_request_dma_done, .async_receive_request_dma_irq,
		.async_transmit_response_context_done, .async_transmit_response_context_irq,
		.async_transmit_request_context_done, .async_transmit_request_context_irq,
		.iso_rx_ctx_event, .iso_rx_ctx_mask, .iso_tx_ctx_event, .iso_tx_ctx_mask, .event_status);
	////////////////////////////////////////////////////////////////////////////////
	task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		fork
			begin do @(posedge aclk); while (!s_axi_awready); s_axi_awvalid <= 1'b0; end
			begin do @(posedge aclk); while (!s_axi_wready); s_axi_wvalid <= 1'b0; end
		join
		while (!s_axi_bvalid) @(posedge aclk);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		v = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic chk(input logic [7:0] a, input logic [22:0] e);
		rd(a, d, r);
		cmp_data(d, {9'h000, e});
		cmp_resp(r, 2'b00);
	endtask
	task automatic clr_all();
		wr(8'h84, 32'hffffffff, r);
		cmp_resp(r, 2'b00);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_alias();
		chk(8'h80, 23'h000000);
		wr(8'h80, 32'hfffeffff, r);
		chk(8'h80, 23'h7e833f);
		interrupt_mask <= 23'h0f0f0f;
		chk(8'h84, 23'h0e030f);
		interrupt_mask <= 23'h7fffff;
		wr(8'h84, 32'h007f0000, r);
		chk(8'h80, 23'h00833f);
		wr(8'h88, 32'hffffffff, r);
		cmp_resp(r, 2'b10);
		rd(8'h40, d, r);
		cmp_data(d, 32'h0);
		cmp_resp(r, 2'b10);
		clr_all();
		chk(8'h80, 23'h000000);
		s_axi_wstrb <= 4'h4;
		wr(8'h80, 32'h00feffff, r);
		s_axi_wstrb <= 4'hf;
		chk(8'h80, 23'h7e0000);
		clr_all();
	endtask
	task automatic t_core();
		@(posedge aclk);
		{lock_response_no_ack, posted_write_host_error} <= 2'b11;
		{response_packet_stored, request_packet_stored} <= 2'b11;
		{async_receive_response_dma_done, async_receive_request_dma_done} <= 2'b11;
		{async_transmit_response_context_done, async_transmit_request_context_done} <= 2'b11;
		{async_receive_response_dma_irq, async_receive_request_dma_irq} <= 4'hd;
		{async_transmit_response_context_irq, async_transmit_request_context_irq} <= 4'he;
		@(posedge aclk);
		{lock_response_no_ack, posted_write_host_error, response_packet_stored} <= 3'h0;
		{request_packet_stored, async_receive_response_dma_done} <= 2'b00;
		{async_receive_request_dma_done, async_transmit_response_context_done} <= 2'b00;
		async_transmit_request_context_done <= 1'b0;
		w(6);
		chk(8'h80, 23'h00033a);
		clr_all();
	endtask
	task automatic t_phy();
		phy_u.pulse(1);
		phy_u.pulse(2);
		phy_u.pulse(0);
		chk(8'h80, 23'h0b8000);
		wr(8'h84, 32'h00020000, r);
		phy_u.pulse(1);
		chk(8'h80, 23'h0a8000);
		phy_u.toggle(3);
		@(posedge aclk);
		core_reg_access <= 1'b1;
		@(posedge aclk);
		core_reg_access <= 1'b0;
		w(4);
		chk(8'h80, 23'h0e8000);
		phy_u.toggle(3);
		clr_all();
	endtask
	task automatic t_cycle();
		phy_u.toggle(4);
		phy_u.pulse(6);
		phy_u.toggle(4);
		chk(8'h80, 23'h100000);
		phy_u.toggle(4);
		chk(8'h80, 23'h500000);
		phy_u.toggle(5);
		chk(8'h80, 23'h700000);
		clr_all();
		phy_u.pulse(6);
		phy_u.toggle(4);
		phy_u.pulse(7);
		chk(8'h80, 23'h100000);
		phy_u.pulse(7);
		chk(8'h80, 23'h500000);
		clr_all();
		phy_u.pulse(6);
		phy_u.toggle(4);
		phy_u.pulse(8);
		chk(8'h80, 23'h500000);
		clr_all();
	endtask
	task automatic t_iso();
		@(posedge aclk);
		iso_rx_ctx_event <= 4'h4;
		iso_rx_ctx_mask <= 4'h4;
		iso_tx_ctx_event <= 4'h8;
		iso_tx_ctx_mask <= 4'h9;
		w(4);
		clr_all();
		chk(8'h80, 23'h0000c0);
		iso_rx_ctx_mask <= 4'h3;
		iso_tx_ctx_event <= 4'h2;
		w(4);
		chk(8'h80, 23'h000000);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("miscompares=%0d cmp_count=%0d", miscompares, cmp_count);
		if (miscompares == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		w(20);
		aresetn <= 1'b1;
		t_alias();
		t_core();
		t_phy();
		t_cycle();
		t_iso();
		give_verdict();
	end
	// The whole sequence needs a few hundred cycles, so twenty thousand means a hang.
	initial begin
		w(20000);
		miscompares++;
		give_verdict();
	end
endmodule
